// ===== include/lesl_pkg.sv
`default_nettype none
// ==========================================
// register map and field layout
package lesl_pkg;
	localparam logic [11:0] LESL_OFS_LINK_CONTROL = 12'h040;
	localparam logic [11:0] LESL_OFS_LINK_EVENT_STATUS = 12'h044;
	localparam logic [11:0] LESL_OFS_LINK_EVENT_ENABLES = 12'h048;
	// link_control fields
	localparam int LESL_CTL_CYCLE_MASTER_BIT = 11;
	localparam int LESL_CTL_OVERRUN_KEEP_BIT = 10;
	localparam int LESL_CTL_CODE_CLEAR_BIT = 8;
	localparam int LESL_CTL_CODE_LSB = 4;
	localparam int LESL_CTL_AUTO_MASTER_BIT = 3;
	// link_event_status fields
	localparam int LESL_EV_HEADER_CRC = 21;
	localparam int LESL_EV_SELFID_FAULT = 20;
	localparam int LESL_EV_ISO_ARB_LOST = 19;
	localparam int LESL_EV_CYCLE_OVERRUN = 18;
	localparam int LESL_EV_CYCLE_MISSING = 17;
	localparam int LESL_EV_CYCLE_ARB_LOST = 16;
	localparam int LESL_EV_PHY_EVENT = 10;
	localparam int LESL_EV_PHY_REG = 9;
	localparam logic [31:0] LESL_EV_MASK = 32'h003F0600;
	localparam logic [2:0] LESL_CODE_NONE = 3'h0;
	localparam logic [31:0] LESL_CTL_RESET = 32'h00000000;
	localparam logic [31:0] LESL_STATUS_RESET = 32'h00000000;
	localparam logic [31:0] LESL_ENABLE_RESET = 32'h00000000;
	localparam logic [1:0] LESL_RESP_OKAY = 2'h0;
	localparam logic [1:0] LESL_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ===== verilog/lesl_event_status.sv
`default_nettype none
// ==========================================
// link event status and control logic
// Overview of operation
// RULE1: keep the first self-ID error code in control bits 6:4; later errors do not replace it.
// RULE2: codes 000 none, 001 not all child, 010 bad PHY ID, 011 phase error.
// RULE3: codes 100 two gaps, 101 large gap, 110 ID in packet, 111 not inverted.
// RULE4: with auto master bit 3 set, becoming root sets cycle master enable.
// RULE5: reserved bits ignore writes and read zero.
// RULE6: header CRC error of a possibly addressed packet sets bit 21.
// RULE7: a received self-ID packet with errors sets bit 20.
// RULE8: a lost isochronous arbitration sets bit 19.
// RULE9: a cycle overrun sets bit 18 and, unless control bit 10 is set, clears cycle master enable together.
// RULE10: two timer rollovers without cycle start, when not master, set bit 17.
// RULE11: a failed cycle start arbitration sets bit 16.
// RULE12: a PHY interrupt over the interface sets bit 10.
// RULE13: a PHY register value placed in the access register sets bit 9.
// RULE14: flags interrupt only when enabled; write one clears, zero keeps.
// RULE15: enable register at 0x048 gates hardware-set flags onto the summary output.
// RULE16: writing one to control bit 8 returns the error code to none.
// RULE17: load the code with the self-ID flag, only while the code reads none.
module lesl_event_status
	import lesl_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic header_crc_event,
	input wire logic selfid_fault_event,
	input wire logic [2:0] selfid_fault_kind,
	input wire logic iso_arb_lost_event,
	input wire logic cycle_overrun_event,
	input wire logic cycle_timer_rollover,
	input wire logic cycle_start_received,
	input wire logic cycle_arb_lost_event,
	input wire logic phy_interrupt_event,
	input wire logic phy_register_event,
	input wire logic became_root_event,
	output logic cycle_master_enable,
	output logic link_interrupt_summary
);
	// ==========================================
	// state
	logic [31:0] status_r, status_nxt;
	logic [31:0] enables_r, enables_nxt;
	logic [2:0] selfid_fault_code_r, selfid_fault_code_nxt;
	logic root_auto_master_r, root_auto_master_nxt;
	logic cycle_master_r, cycle_master_nxt;
	logic overrun_keep_r, overrun_keep_nxt;
	logic [1:0] roll_cnt_r, roll_cnt_nxt;
	logic aw_held_r, aw_held_nxt;
	logic w_held_r, w_held_nxt;
	logic [11:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic summary_r, summary_nxt;
	logic do_write;
	logic [31:0] wmask;
	logic [31:0] wbits;
	logic [31:0] ctl_view;
	logic [31:0] set_vec;

	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready = !w_held_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign cycle_master_enable = cycle_master_r;
	assign link_interrupt_summary = summary_r;

	// ==========================================
	// write capture and decode
	assign do_write = aw_held_r && w_held_r && !bvalid_r;
	assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
	assign wbits = wdata_r & wmask;

	always_comb begin
		ctl_view = 32'h00000000;
		ctl_view[LESL_CTL_CYCLE_MASTER_BIT] = cycle_master_r;
		ctl_view[LESL_CTL_OVERRUN_KEEP_BIT] = overrun_keep_r;
		ctl_view[LESL_CTL_CODE_LSB +: 3] = selfid_fault_code_r; // see RULE1
		ctl_view[LESL_CTL_AUTO_MASTER_BIT] = root_auto_master_r;
	end

	always_comb begin
		set_vec = 32'h00000000;
		set_vec[LESL_EV_HEADER_CRC] = header_crc_event; // see RULE6
		set_vec[LESL_EV_SELFID_FAULT] = selfid_fault_event; // see RULE7
		set_vec[LESL_EV_ISO_ARB_LOST] = iso_arb_lost_event; // see RULE8
		set_vec[LESL_EV_CYCLE_OVERRUN] = cycle_overrun_event; // see RULE9
		set_vec[LESL_EV_CYCLE_MISSING] = !cycle_master_r && cycle_timer_rollover &&
			!cycle_start_received && roll_cnt_r == 2'h1; // see RULE10
		set_vec[LESL_EV_CYCLE_ARB_LOST] = cycle_arb_lost_event; // see RULE11
		set_vec[LESL_EV_PHY_EVENT] = phy_interrupt_event; // see RULE12
		set_vec[LESL_EV_PHY_REG] = phy_register_event; // see RULE13
	end

	// ==========================================
	// bus handshake
	always_comb begin
		aw_held_nxt = aw_held_r;
		w_held_nxt = w_held_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_nxt = 1'b1;
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		if (do_write) begin
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			case ({awaddr_r[11:2], 2'h0})
				LESL_OFS_LINK_CONTROL, LESL_OFS_LINK_EVENT_STATUS,
				LESL_OFS_LINK_EVENT_ENABLES: bresp_nxt = LESL_RESP_OKAY;
				default: bresp_nxt = LESL_RESP_SLVERR;
			endcase
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = LESL_RESP_OKAY;
			case ({s_axi_araddr[11:2], 2'h0})
				LESL_OFS_LINK_CONTROL: rdata_nxt = ctl_view;
				LESL_OFS_LINK_EVENT_STATUS: rdata_nxt = status_r;
				LESL_OFS_LINK_EVENT_ENABLES: rdata_nxt = enables_r;
				default: begin
					rdata_nxt = 32'h00000000;
					rresp_nxt = LESL_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	// ==========================================
	// registers and event logic
	always_comb begin
		status_nxt = status_r;
		enables_nxt = enables_r;
		selfid_fault_code_nxt = selfid_fault_code_r;
		root_auto_master_nxt = root_auto_master_r;
		cycle_master_nxt = cycle_master_r;
		overrun_keep_nxt = overrun_keep_r;
		roll_cnt_nxt = roll_cnt_r;
		if (do_write && {awaddr_r[11:2], 2'h0} == LESL_OFS_LINK_CONTROL) begin
			root_auto_master_nxt = wbits[LESL_CTL_AUTO_MASTER_BIT];
			overrun_keep_nxt = wbits[LESL_CTL_OVERRUN_KEEP_BIT];
			if (!root_auto_master_r) begin
				cycle_master_nxt = wbits[LESL_CTL_CYCLE_MASTER_BIT];
			end
			if (wbits[LESL_CTL_CODE_CLEAR_BIT]) begin
				selfid_fault_code_nxt = LESL_CODE_NONE; // see RULE16
			end
		end
		if (do_write && {awaddr_r[11:2], 2'h0} == LESL_OFS_LINK_EVENT_STATUS) begin
			status_nxt = status_r & ~(wbits & LESL_EV_MASK); // see RULE14
		end
		if (do_write && {awaddr_r[11:2], 2'h0} == LESL_OFS_LINK_EVENT_ENABLES) begin
			enables_nxt = wbits & LESL_EV_MASK; // see RULE5
		end
		status_nxt = status_nxt | set_vec; // see RULE14
		if (selfid_fault_event && selfid_fault_code_r == LESL_CODE_NONE) begin
			selfid_fault_code_nxt = selfid_fault_kind; // see RULE2 RULE3 RULE17
		end
		if (root_auto_master_r && became_root_event) begin
			cycle_master_nxt = 1'b1; // see RULE4
		end
		if (cycle_overrun_event && !overrun_keep_r) begin
			cycle_master_nxt = 1'b0; // see RULE9
		end
		if (cycle_master_r || cycle_start_received) begin
			roll_cnt_nxt = 2'h0;
		end else if (cycle_timer_rollover) begin
			roll_cnt_nxt = (roll_cnt_r == 2'h1) ? 2'h0 : 2'h1; // see RULE10
		end
		summary_nxt = |(status_nxt & enables_r); // see RULE15
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_r <= LESL_STATUS_RESET;
			enables_r <= LESL_ENABLE_RESET;
			selfid_fault_code_r <= LESL_CODE_NONE;
			root_auto_master_r <= 1'b0;
			cycle_master_r <= 1'b0;
			overrun_keep_r <= 1'b0;
			roll_cnt_r <= 2'h0;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= 12'h000;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= LESL_RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= LESL_RESP_OKAY;
			summary_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
			enables_r <= enables_nxt;
			selfid_fault_code_r <= selfid_fault_code_nxt;
			root_auto_master_r <= root_auto_master_nxt;
			cycle_master_r <= cycle_master_nxt;
			overrun_keep_r <= overrun_keep_nxt;
			roll_cnt_r <= roll_cnt_nxt;
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			summary_r <= summary_nxt;
		end
	end

	// ==========================================
	// checks
	a_code_first_kept: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE1
		$past(selfid_fault_code_r) != LESL_CODE_NONE && !$past(do_write)
		|-> selfid_fault_code_r == $past(selfid_fault_code_r))
		else $error("self-ID code changed while holding an error");
	a_code_load: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE17
		selfid_fault_event && selfid_fault_code_r == LESL_CODE_NONE
		|=> selfid_fault_code_r == $past(selfid_fault_kind) && status_r[LESL_EV_SELFID_FAULT])
		else $error("self-ID code not loaded with its flag");
	a_code_clear: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE16
		do_write && {awaddr_r[11:2], 2'h0} == LESL_OFS_LINK_CONTROL &&
		wbits[LESL_CTL_CODE_CLEAR_BIT] && !selfid_fault_event
		|=> selfid_fault_code_r == LESL_CODE_NONE)
		else $error("self-ID code not cleared by control write");
	a_auto_master: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE4
		root_auto_master_r && became_root_event && !cycle_overrun_event
		|=> cycle_master_enable)
		else $error("cycle master not set on becoming root");
	a_master_locked: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE4
		do_write && {awaddr_r[11:2], 2'h0} == LESL_OFS_LINK_CONTROL && root_auto_master_r &&
		!became_root_event && !cycle_overrun_event
		|=> cycle_master_enable == $past(cycle_master_enable))
		else $error("cycle master written while automatic set is on");
	a_overrun_clear: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE9
		cycle_overrun_event && !overrun_keep_r
		|=> !cycle_master_enable && status_r[LESL_EV_CYCLE_OVERRUN])
		else $error("overrun did not clear master and set flag");
	a_overrun_keep: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE9
		cycle_overrun_event && overrun_keep_r && !became_root_event && !do_write
		|=> cycle_master_enable == $past(cycle_master_enable))
		else $error("overrun changed master although clearing is off");
	a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE5
		(status_r & ~LESL_EV_MASK) == 32'h00000000 &&
		(enables_r & ~LESL_EV_MASK) == 32'h00000000)
		else $error("reserved bits not zero");
	a_header_set: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE6
		header_crc_event |=> status_r[LESL_EV_HEADER_CRC])
		else $error("header flag not set");
	a_selfid_set: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE7
		selfid_fault_event |=> status_r[LESL_EV_SELFID_FAULT])
		else $error("self-ID flag not set");
	a_iso_set: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE8
		iso_arb_lost_event |=> status_r[LESL_EV_ISO_ARB_LOST])
		else $error("isochronous arbitration flag not set");
	a_arb_set: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE11
		cycle_arb_lost_event |=> status_r[LESL_EV_CYCLE_ARB_LOST])
		else $error("cycle arbitration flag not set");
	a_phy_set: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE12
		phy_interrupt_event |=> status_r[LESL_EV_PHY_EVENT])
		else $error("PHY interrupt flag not set");
	a_phyreg_set: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE13
		phy_register_event |=> status_r[LESL_EV_PHY_REG])
		else $error("PHY register flag not set");
	a_lost_blocked: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE10
		cycle_start_received || cycle_master_r
		|=> !status_r[LESL_EV_CYCLE_MISSING] || $past(status_r[LESL_EV_CYCLE_MISSING]))
		else $error("cycle lost flag set despite start or master");
	a_summary_gate: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE15
		##1 link_interrupt_summary == |(status_r & $past(enables_r)))
		else $error("summary does not follow enabled flags");
	a_summary_off: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE15
		enables_r == 32'h00000000 |=> !link_interrupt_summary)
		else $error("summary raised with all enables off");
	a_flag_held: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE14
		status_r[LESL_EV_CYCLE_ARB_LOST] && !do_write
		|=> status_r[LESL_EV_CYCLE_ARB_LOST])
		else $error("flag dropped without a write");
	a_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE14
		do_write && {awaddr_r[11:2], 2'h0} == LESL_OFS_LINK_EVENT_STATUS &&
		wbits[LESL_EV_CYCLE_ARB_LOST] && !cycle_arb_lost_event
		|=> !status_r[LESL_EV_CYCLE_ARB_LOST])
		else $error("flag not cleared by writing one");
	c_selfid_load: cover property (@(posedge aclk) disable iff (!aresetn)
		selfid_fault_event && selfid_fault_code_r == LESL_CODE_NONE);
	c_summary: cover property (@(posedge aclk) disable iff (!aresetn)
		link_interrupt_summary ##1 !link_interrupt_summary);
	c_lost: cover property (@(posedge aclk) disable iff (!aresetn)
		set_vec[LESL_EV_CYCLE_MISSING]);
	c_auto_root: cover property (@(posedge aclk) disable iff (!aresetn)
		root_auto_master_r && became_root_event);
	c_overrun_keep: cover property (@(posedge aclk) disable iff (!aresetn)
		cycle_overrun_event && overrun_keep_r);
endmodule // lesl_event_status
`default_nettype wire

// ===== sim/lesl_event_src.sv
`default_nettype none
// ==========================================
// receiver, transmitter and phy interface event model
module lesl_event_src (
	input wire logic aclk,
	output logic [9:0] ev,
	output logic [2:0] kind
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ev = 10'h000;
		kind = 3'h7;
	end
	// one-cycle pulse, kind valid only with it, then a spare cycle
	task automatic pulse(input int i, input logic [2:0] k);
		ev[i] <= 1'b1;
		kind <= k;
		@(posedge aclk);
		ev <= 10'h000;
		kind <= ~k;
		@(posedge aclk);
	endtask
endmodule // lesl_event_src
`default_nettype wire

// ===== sim/link_event_status_logic_tb.sv
`default_nettype none
module link_event_status_logic_tb import lesl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, cme, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, d;
	logic [1:0] r;
	logic [9:0] ev;
	logic [2:0] kind;
	int fails = 0;
	int compares = 0;
	int cyc = 0;
	always #2 aclk = ~aclk;
	lesl_event_src phy (.aclk(aclk), .ev(ev), .kind(kind));
	lesl_event_status dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.header_crc_event(ev[0]), .selfid_fault_event(ev[1]), .selfid_fault_kind(kind),
		.iso_arb_lost_event(ev[2]), .cycle_overrun_event(ev[3]), .cycle_timer_rollover(ev[4]),
		.cycle_start_received(ev[5]), .cycle_arb_lost_event(ev[6]),
		.phy_interrupt_event(ev[7]), .phy_register_event(ev[8]), .became_root_event(ev[9]),
		.cycle_master_enable(cme), .link_interrupt_summary(irq));
	// ==========================================
	// bus and reporting tasks
	task automatic print_verdict;
		if (fails == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		logic ta, tw, tk;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			#1;
			ta = awvalid & awready;
			tw = wvalid & wready;
			tk = bvalid & bready;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tk) bready <= 1'b0;
		end while (!tk);
		@(posedge aclk);
	endtask
	task automatic rd(input logic [11:0] a);
		logic ta, tk;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			#1;
			ta = arvalid & arready;
			tk = rvalid & rready;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tk) rready <= 1'b0;
		end while (!tk);
		@(posedge aclk);
	endtask
	// ==========================================
	// scenarios
	task automatic t_regs;
		rd(LESL_OFS_LINK_CONTROL);
		chk(d, LESL_CTL_RESET);
		rd(LESL_OFS_LINK_EVENT_STATUS);
		chk(d, LESL_STATUS_RESET);
		wr(LESL_OFS_LINK_EVENT_ENABLES, 32'hFFFFFFFF);
		rd(LESL_OFS_LINK_EVENT_ENABLES);
		chk(d, LESL_EV_MASK);
		wr(LESL_OFS_LINK_CONTROL, 32'hFFFFFCF7);
		rd(LESL_OFS_LINK_CONTROL);
		chk(d, 32'h00000C00);
		wr(LESL_OFS_LINK_CONTROL, 32'h00000000);
		wr(LESL_OFS_LINK_EVENT_STATUS, 32'hFFFFFFFF);
		rd(LESL_OFS_LINK_EVENT_STATUS);
		chk(d, 32'h00000000);
		rd(12'h04C);
		chk({d[31:2], r}, {30'h0, LESL_RESP_SLVERR});
	endtask
	task automatic t_flags;
		int src [5] = '{0, 2, 6, 7, 8};
		int pos [5] = '{21, 19, 16, 10, 9};
		for (int i = 0; i < 5; i++) begin
			phy.pulse(src[i], 3'h1);
			rd(LESL_OFS_LINK_EVENT_STATUS);
			chk(d, 32'h1 << pos[i]);
			chk({31'h0, irq}, 32'h1);
			wr(LESL_OFS_LINK_EVENT_STATUS, 32'h0);
			rd(LESL_OFS_LINK_EVENT_STATUS);
			chk(d, 32'h1 << pos[i]);
			wr(LESL_OFS_LINK_EVENT_STATUS, 32'h1 << pos[i]);
			rd(LESL_OFS_LINK_EVENT_STATUS);
			chk({d[31:1], irq}, 32'h0);
		end
		wr(LESL_OFS_LINK_EVENT_ENABLES, 32'h0);
		phy.pulse(7, 3'h1);
		rd(LESL_OFS_LINK_EVENT_STATUS);
		chk({d[31:1], irq}, 32'h00000400);
		wr(LESL_OFS_LINK_EVENT_STATUS, 32'h00000400);
	endtask
	task automatic t_code;
		int j;
		for (int k = 1; k < 8; k++) begin
			j = (k % 7) + 1;
			phy.pulse(1, k[2:0]);
			phy.pulse(1, j[2:0]);
			rd(LESL_OFS_LINK_CONTROL);
			chk(d, {25'h0, k[2:0], 4'h0});
			rd(LESL_OFS_LINK_EVENT_STATUS);
			chk(d, 32'h00100000);
			wr(LESL_OFS_LINK_EVENT_STATUS, 32'h00100000);
			wr(LESL_OFS_LINK_CONTROL, 32'h00000100);
			rd(LESL_OFS_LINK_CONTROL);
			chk(d, 32'h0);
		end
	endtask
	task automatic t_lost;
		phy.pulse(4, 3'h1);
		phy.pulse(5, 3'h1);
		phy.pulse(4, 3'h1);
		rd(LESL_OFS_LINK_EVENT_STATUS);
		chk(d, 32'h0);
		phy.pulse(4, 3'h1);
		rd(LESL_OFS_LINK_EVENT_STATUS);
		chk(d, 32'h00020000);
		wr(LESL_OFS_LINK_EVENT_STATUS, 32'h00020000);
	endtask
	task automatic t_master;
		wr(LESL_OFS_LINK_CONTROL, 32'h00000008);
		phy.pulse(9, 3'h1);
		rd(LESL_OFS_LINK_CONTROL);
		chk({d[31:1], cme}, 32'h00000809);
		phy.pulse(3, 3'h1);
		rd(LESL_OFS_LINK_EVENT_STATUS);
		chk({d[31:1], cme}, 32'h00040000);
		rd(LESL_OFS_LINK_CONTROL);
		chk(d, 32'h00000008);
		wr(LESL_OFS_LINK_EVENT_STATUS, 32'h00040000);
		wr(LESL_OFS_LINK_CONTROL, 32'h00000C00);
		rd(LESL_OFS_LINK_CONTROL);
		chk(d, 32'h00000400);
		wr(LESL_OFS_LINK_CONTROL, 32'h00000C00);
		phy.pulse(3, 3'h1);
		rd(LESL_OFS_LINK_EVENT_STATUS);
		chk({d[31:1], cme}, 32'h00040001);
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			print_verdict;
		end
	end
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs;
		t_flags;
		t_code;
		t_lost;
		t_master;
		print_verdict;
	end
endmodule // link_event_status_logic_tb
`default_nettype wire
